// [hw/lrs_register_slave.sv]
`timescale 1ns/1ps
`default_nettype none
`include "lrs_map.svh"

module lrs_register_slave
  import lrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_high_pin,
  input wire logic addr_select_low_pin,
  output logic bus_busy,
  output logic [7:0] misc_configuration,
  output logic soft_reset_pulse,
  output logic reg_write_strobe,
  output logic [7:0] reg_write_index,
  output logic [7:0] reg_write_data
);

  // link domain: scl_clk edges, plus the data-line edge catchers
  lrs_state_e state;
  logic [3:0] bit_cnt;
  logic sda_rise;
  logic read_dir;
  lrs_byte_t shift_in;
  lrs_byte_t tx_shift;
  lrs_byte_t index;
  lrs_byte_t rd_req_index;
  lrs_byte_t wr_index;
  lrs_byte_t wr_data;
  logic wr_tgl;
  logic rd_tgl;
  logic [2:0] link_sync;

  // core domain byte read by the link once its request has settled
  lrs_byte_t rd_byte;

  wire logic autoinc_en = link_sync[2];
  wire logic [1:0] asel = link_sync[1:0];
  wire logic [6:0] own_addr = `LRS_SLAVE_BASE + {5'h00, asel};
  wire lrs_byte_t byte_in = {shift_in[6:0], sda_rise};
  wire logic byte_done = bit_cnt == `LRS_LAST_BIT;
  wire logic ack_slot = bit_cnt == `LRS_ACK_SLOT;

  // caught on data edges: a stop then a start has no clock fall between
  logic start_tgl;
  logic stop_tgl;
  logic [1:0] cond_seen;
  wire logic start_cond = start_tgl ^ cond_seen[1];
  wire logic stop_cond = stop_tgl ^ cond_seen[0];

  wire logic addr_match = byte_in[7:1] == own_addr;
  wire logic addr_ok = (state == LRS_ADDR) && byte_done && addr_match;
  wire logic addr_bad = (state == LRS_ADDR) && byte_done && !addr_match;
  wire logic index_done = (state == LRS_INDEX) && byte_done;
  wire logic data_done = (state == LRS_WDATA) && byte_done;
  wire logic data_ack_end = (state == LRS_WDATA) && ack_slot;
  wire logic tx_ack_end = (state == LRS_RDATA) && ack_slot;
  wire logic master_ack = tx_ack_end && !sda_rise;
  wire logic master_nack = tx_ack_end && sda_rise;
  wire logic read_start = (state == LRS_ADDR) && ack_slot && read_dir;
  wire logic load_tx = read_start || master_ack;
  wire logic tx_more = (state == LRS_RDATA) && (bit_cnt < `LRS_LAST_BIT);

  function automatic lrs_byte_t step_index(input lrs_byte_t idx, input logic en);
    logic frozen;
    frozen = (idx >= `LRS_NOINC_LO) && (idx <= `LRS_NOINC_HI);
    step_index = (en && !frozen) ? idx + `LRS_BIT_STEP : idx;
  endfunction : step_index

  wire lrs_byte_t next_index = step_index(index, autoinc_en);
  wire lrs_byte_t prefetch_index = step_index(rd_req_index, autoinc_en);

  lrs_state_e after_ack;
  always_comb begin
    case (state)
      LRS_ADDR: after_ack = read_dir ? LRS_RDATA : LRS_INDEX;
      LRS_INDEX: after_ack = LRS_WDATA;
      LRS_WDATA: after_ack = LRS_WDATA;
      LRS_RDATA: after_ack = LRS_RDATA;
      default: after_ack = LRS_IDLE;
    endcase
  end

  // pins are static straps; caught on the first link clocks of a frame
  lrs_sync #(
    .WIDTH(3)
  ) u_link_sync (
    .clk(scl_clk),
    .rst_b(rst_b),
    .d({misc_configuration[`LRS_AUTOINC_BIT], addr_select_high_pin, addr_select_low_pin}),
    .q(link_sync)
  );

  // data bits are taken while the clock is high, never on the core clock
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_rise <= 1'b1;
    end else begin
      sda_rise <= sda_in;
    end
  end

  always_ff @(negedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      start_tgl <= 1'b0;
    end else if (scl_clk) begin
      start_tgl <= !start_tgl;
    end
  end
  always_ff @(posedge sda_in or negedge rst_b) begin
    if (!rst_b) begin
      stop_tgl <= 1'b0;
    end else if (scl_clk) begin
      stop_tgl <= !stop_tgl;
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= LRS_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_cond) begin
      state <= LRS_ADDR;
      bit_cnt <= 4'h0;
    end else if (stop_cond || addr_bad || master_nack) begin
      state <= LRS_IDLE;
      bit_cnt <= 4'h0;
    end else if (state == LRS_IDLE) begin
      bit_cnt <= 4'h0;
    end else if (ack_slot) begin
      state <= after_ack;
      bit_cnt <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + `LRS_BIT_STEP;
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_in <= '0;
      read_dir <= 1'b0;
    end else begin
      shift_in <= byte_in;
      if (addr_ok) begin
        read_dir <= byte_in[0];
      end
    end
  end

  // open drain: only ever released or pulled low
  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe <= 1'b0;
    end else if (addr_ok || index_done || data_done) begin
      sda_oe <= 1'b1;
    end else if (load_tx) begin
      sda_oe <= !rd_byte[7];
    end else if (tx_more) begin
      sda_oe <= !tx_shift[6];
    end else begin
      sda_oe <= 1'b0;
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_out <= 1'b0;
      cond_seen <= 2'b00;
    end else begin
      sda_out <= 1'b0;
      cond_seen <= {start_tgl, stop_tgl};
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift <= '0;
    end else if (load_tx) begin
      tx_shift <= rd_byte;
    end else if (tx_more) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      index <= '0;
    end else if (index_done) begin
      index <= byte_in;
    end else if (data_ack_end || master_ack) begin
      index <= next_index;
    end
  end

  // read prefetch stays one byte ahead so the next byte is ready when
  // the master acknowledges; the core has a whole byte time to fetch it
  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_req_index <= '0;
      rd_tgl <= 1'b0;
    end else if (index_done) begin
      rd_req_index <= byte_in;
      rd_tgl <= !rd_tgl;
    end else if (data_ack_end) begin
      rd_req_index <= next_index;
      rd_tgl <= !rd_tgl;
    end else if (load_tx) begin
      rd_req_index <= prefetch_index;
      rd_tgl <= !rd_tgl;
    end
  end

  always_ff @(negedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_index <= '0;
      wr_data <= '0;
      wr_tgl <= 1'b0;
    end else if (data_done) begin
      wr_index <= index;
      wr_data <= byte_in;
      wr_tgl <= !wr_tgl;
    end
  end

  // core domain: sys_clk
  logic [3:0] core_sync;
  logic [3:0] core_prev;
  lrs_byte_t regs [`LRS_REG_DEPTH];

  lrs_sync #(
    .WIDTH(4)
  ) u_core_sync (
    .clk(sys_clk),
    .rst_b(rst_b),
    .d({scl_clk, sda_in, wr_tgl, rd_tgl}),
    .q(core_sync)
  );

  wire logic scl_s = core_sync[3];
  wire logic sda_s = core_sync[2];
  wire logic scl_high = scl_s && core_prev[3];
  wire logic bus_start = scl_high && core_prev[2] && !sda_s;
  wire logic bus_stop = scl_high && !core_prev[2] && sda_s;
  wire logic wr_event = core_sync[1] ^ core_prev[1];
  wire logic rd_event = core_sync[0] ^ core_prev[0];
  wire logic wr_mapped = wr_index <= `LRS_REG_TOP;
  wire logic soft_hit = wr_event && (wr_index == `LRS_SOFT_RESET_ADDR)
    && (wr_data == `LRS_SOFT_RESET_KEY);
  wire logic store_hit = wr_event && wr_mapped && (wr_index != `LRS_SOFT_RESET_ADDR);
  wire logic rd_mapped = (rd_req_index <= `LRS_REG_TOP)
    && (rd_req_index != `LRS_SOFT_RESET_ADDR);

  assign misc_configuration = regs[`LRS_MISC_SLOT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_prev <= 4'h0;
    end else begin
      core_prev <= core_sync;
    end
  end

  // start has priority when both land in one core cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_busy <= 1'b0;
    end else if (bus_start) begin
      bus_busy <= 1'b1;
    end else if (bus_stop) begin
      bus_busy <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `LRS_REG_DEPTH; i++) begin
        regs[i] <= `LRS_REG_RESET;
      end
    end else if (soft_hit) begin
      for (int i = 0; i < `LRS_REG_DEPTH; i++) begin
        regs[i] <= `LRS_REG_RESET;
      end
    end else if (store_hit) begin
      regs[wr_index[5:0]] <= wr_data;
    end
  end

  // reset register is write-only and unmapped indices read as zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_byte <= '0;
    end else if (rd_event) begin
      rd_byte <= rd_mapped ? regs[rd_req_index[5:0]] : `LRS_REG_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_pulse <= 1'b0;
      reg_write_strobe <= 1'b0;
      reg_write_index <= '0;
      reg_write_data <= '0;
    end else begin
      soft_reset_pulse <= soft_hit;
      reg_write_strobe <= store_hit;
      if (store_hit) begin
        reg_write_index <= wr_index;
        reg_write_data <= wr_data;
      end
    end
  end

endmodule : lrs_register_slave

`default_nettype wire

// [pkg/lrs_map.svh]
`ifndef LRS_MAP_SVH
`define LRS_MAP_SVH

// register file image
`define LRS_REG_TOP 8'h3f
`define LRS_REG_DEPTH 64
`define LRS_REG_RESET 8'h00
`define LRS_MISC_SLOT 6'h36
`define LRS_AUTOINC_BIT 6
`define LRS_SOFT_RESET_ADDR 8'h3d
`define LRS_SOFT_RESET_KEY 8'hff

// index range that never auto-increments
`define LRS_NOINC_LO 8'h16
`define LRS_NOINC_HI 8'h1e

// slave address base, offset by the two select pins
`define LRS_SLAVE_BASE 7'h32

// bit positions inside a nine-clock byte slot
`define LRS_LAST_BIT 4'h7
`define LRS_ACK_SLOT 4'h8
`define LRS_BIT_STEP 4'h1

`endif

// [pkg/lrs_pkg.sv]
package lrs_pkg;

  typedef logic [7:0] lrs_byte_t;

  typedef enum logic [2:0] {
    LRS_IDLE = 3'b000,
    LRS_ADDR = 3'b001,
    LRS_INDEX = 3'b010,
    LRS_WDATA = 3'b011,
    LRS_RDATA = 3'b100
  } lrs_state_e;

endpackage : lrs_pkg

// [hw/lrs_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-stage level synchroniser; first stage feeds only the second
module lrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : lrs_sync

`default_nettype wire

// [test/lrs_register_slave_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module lrs_register_slave_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic bus_busy,
  input wire logic [7:0] misc_configuration,
  input wire logic soft_reset_pulse,
  input wire logic reg_write_strobe,
  input wire logic [7:0] reg_write_index,
  input wire logic [7:0] reg_write_data
);
  // scl is sampled as data; its phases are far longer than a core cycle
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_DRIVE_LOW_ONLY: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  AST_SDA_MOVES_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("data drive changed while clock high");
  AST_BUSY_AT_START: assert property ($fell(sda_in) && scl_clk |-> ##[1:6] bus_busy)
    else $error("start not flagged busy");
  AST_FREE_AT_STOP: assert property ($rose(sda_in) && scl_clk |-> ##[1:6] !bus_busy)
    else $error("stop not flagged free");
  AST_QUIET_WHEN_FREE: assert property (!bus_busy |-> !sda_oe)
    else $error("data driven on a free bus");
  AST_SRST_ONE_CYCLE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  AST_SRST_CLEARS: assert property (soft_reset_pulse |-> ##[1:3] misc_configuration == 8'h00)
    else $error("soft reset left misc set");
  AST_STROBE_ONE_CYCLE: assert property (reg_write_strobe |=> !reg_write_strobe)
    else $error("write strobe too long");
  AST_STROBE_MAPPED: assert property (reg_write_strobe |-> reg_write_index <= 8'h3f && reg_write_index != 8'h3d)
    else $error("strobe for unmapped index");
  AST_MISC_TRACKS: assert property (reg_write_strobe && reg_write_index == 8'h36 |-> ##[0:3] misc_configuration == reg_write_data)
    else $error("misc not updated");
  AST_EVENTS_IN_FRAME: assert property (reg_write_strobe || soft_reset_pulse |-> bus_busy)
    else $error("register event outside a frame");
endmodule : lrs_register_slave_checker

bind lrs_register_slave lrs_register_slave_checker u_lrs_register_slave_checker (.sys_clk, .rst_b,
  .scl_clk, .sda_in, .sda_out, .sda_oe, .bus_busy, .misc_configuration, .soft_reset_pulse,
  .reg_write_strobe, .reg_write_index, .reg_write_data);

`default_nettype wire

// [test/lrs_master_model.sv]
`timescale 1ns/1ps
`default_nettype none

// bus master; scl rests high between frames
module lrs_master_model (
  input wire logic lnk_clk,
  input wire logic sda_in,
  output logic scl_clk,
  output logic sda_low
);
  initial scl_clk = 1'b1;
  initial sda_low = 1'b0;
  task automatic ph(input int n);
    repeat (n) @(posedge lnk_clk);
  endtask : ph
  // also a repeated start; short hold after scl fall avoids a false stop
  task automatic st();
    ph(2);
    sda_low <= 1'b0;
    ph(13);
    scl_clk <= 1'b1;
    ph(13);
    sda_low <= 1'b1;
    ph(13);
    scl_clk <= 1'b0;
  endtask : st
  task automatic sp();
    ph(2);
    sda_low <= 1'b1;
    ph(13);
    scl_clk <= 1'b1;
    ph(13);
    sda_low <= 1'b0;
    ph(13);
  endtask : sp
  // nine clocks, msb first; bit 0 is the acknowledge slot
  task automatic slot(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      ph(2);
      sda_low <= ~tx[i];
      ph(13);
      scl_clk <= 1'b1;
      ph(13);
      rx[i] = sda_in;
      scl_clk <= 1'b0;
    end
  endtask : slot
endmodule : lrs_master_model

`default_nettype wire

// [test/tb_lrs_register_slave.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_lrs_register_slave
  import lrs_pkg::*;
;
  logic sys_clk = 1'b0, lnk_clk = 1'b0, rst_b = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0;
  logic scl_clk, sda_low, sda_out, sda_oe, bus_busy, soft_reset_pulse, reg_write_strobe;
  logic [7:0] misc_configuration, reg_write_index, reg_write_data;
  wire logic sda_in = ~sda_low & (sda_oe ? sda_out : 1'b1);
  lrs_byte_t mem [64];
  logic [15:0] got_q[$], exp_q[$];
  int n_errors = 0, checked = 0, n_srst = 0;

  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    #3;
    forever #6 lnk_clk = ~lnk_clk;
  end

  lrs_register_slave u_lrs_register_slave (.sys_clk, .rst_b, .scl_clk, .sda_in, .sda_out, .sda_oe,
    .addr_select_high_pin(sel_hi), .addr_select_low_pin(sel_lo), .bus_busy, .misc_configuration,
    .soft_reset_pulse, .reg_write_strobe, .reg_write_index, .reg_write_data);
  lrs_master_model u_lrs_master_model (.lnk_clk, .sda_in, .scl_clk, .sda_low);

  always @(posedge sys_clk) begin
    if (reg_write_strobe === 1'b1) got_q.push_back({reg_write_index, reg_write_data});
    if (soft_reset_pulse === 1'b1) n_srst++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  function automatic lrs_byte_t step(input lrs_byte_t i);
    return (mem[6'h36][6] && (i < 8'h16 || i > 8'h1e)) ? i + 8'h01 : i;
  endfunction : step
  function automatic logic [6:0] me();
    return 7'h32 + {5'h00, sel_hi, sel_lo};
  endfunction : me
  task automatic tx(input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    u_lrs_master_model.slot({b, 1'b1}, rx);
    chk(16'(rx[0]), 16'(!ack));
  endtask : tx
  task automatic hdr(input lrs_byte_t idx);
    u_lrs_master_model.st();
    tx({me(), 1'b0}, 1'b1);
    tx(idx, 1'b1);
  endtask : hdr
  task automatic wr(input lrs_byte_t idx, input lrs_byte_t d[$]);
    lrs_byte_t i;
    i = idx;
    got_q.delete();
    exp_q.delete();
    hdr(idx);
    foreach (d[k]) begin
      tx(d[k], 1'b1);
      if (i == 8'h3d && d[k] == 8'hff) begin
        mem = '{default: 8'h00};
      end else if (i != 8'h3d) begin
        exp_q.push_back({i, d[k]});
        mem[i[5:0]] = d[k];
      end
      i = step(i);
    end
    u_lrs_master_model.sp();
    repeat (8) @(posedge sys_clk);
    chk(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[k]) chk(got_q[k], exp_q[k]);
  endtask : wr
  task automatic rd(input lrs_byte_t idx, input int n);
    logic [8:0] rx;
    lrs_byte_t i;
    i = idx;
    hdr(idx);
    u_lrs_master_model.st();
    tx({me(), 1'b1}, 1'b1);
    for (int k = 0; k < n; k++) begin
      u_lrs_master_model.slot({8'hff, k == n - 1}, rx);
      chk(16'(rx[8:1]), 16'(mem[i[5:0]]));
      i = step(i);
    end
    u_lrs_master_model.sp();
  endtask : rd

  initial begin
    #1_000_000;
    n_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(61));
    mem = '{default: 8'h00};
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(16'(misc_configuration), 16'h0000);
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      @(negedge sys_clk) {sel_hi, sel_lo} = 2'(s);
      u_lrs_master_model.st();
      tx({me() ^ 7'h01, 1'b0}, 1'b0);
      chk(16'(bus_busy), 16'h0001);
      tx(8'($urandom), 1'b0);
      u_lrs_master_model.sp();
      repeat (8) @(posedge sys_clk);
      chk(16'(bus_busy), 16'h0000);
      wr(8'(s), {8'($urandom)});
    end
    $display("address test done");
    wr(8'h20, {8'($urandom), 8'($urandom)});
    wr(8'h36, {8'h40});
    chk(16'(misc_configuration), 16'h0040);
    wr(8'h10, {8'($urandom), 8'($urandom), 8'($urandom)});
    wr(8'h15, {8'($urandom), 8'($urandom), 8'($urandom)});
    wr(8'h3c, {8'($urandom), 8'h5a, 8'($urandom)});
    $display("write test done");
    rd(8'h10, 4);
    rd(8'h14, 4);
    rd(8'h3b, 4);
    $display("read test done");
    wr(8'h3d, {8'hff});
    chk(16'(n_srst), 16'h0001);
    chk(16'(misc_configuration), 16'h0000);
    rd(8'h10, 2);
    $display("soft reset test done");
    wrap_up();
  end
endmodule : tb_lrs_register_slave

`default_nettype wire
